/* core/alitm_cfg.svh */
`ifndef ALITM_CFG_SVH
`define ALITM_CFG_SVH
// Overview of operation
// - Plain sum adds operand into accumulator in one cycle; register/indirect 1 byte, else 2.
// - Sum-with-carry adds operand plus carry into accumulator in one cycle; register form 1 byte.
// - Sum-with-carry with direct source is two bytes, one machine cycle.
// - Minus-with-borrow immediate subtracts operand and borrow; two bytes, one cycle.
// - Minus-with-borrow direct is two bytes, one cycle; register and indirect one byte.
// - AND into accumulator is one cycle for all sources; immediate form two bytes.
// - AND immediate into direct byte is three bytes, two machine cycles.
// - AND accumulator into direct byte is two bytes, one cycle, written back there.
// - OR immediate into direct byte is three bytes, two machine cycles.
// - OR with bank register writes accumulator; one byte, one cycle.
// - XOR immediate into direct byte is three bytes, two machine cycles.
// - XOR accumulator into direct byte two bytes, one cycle; accumulator forms one cycle.
// - Left rotate through carry treats carry as ninth bit; both left rotates 1/1.
// - Right rotate through carry and plain right rotate each one byte, one cycle.
// - Nibble exchange is one byte, one machine cycle.
// - Nibble exchange swaps bits 3-0 with 7-4 and leaves flags alone.
// - Borrow sets carry from bit 7, half-borrow from bit 3, excess when 6 xor 7.
// - Read-modify-write of an output port reads its output latch, not the pins.

`define ALITM_CLK_NS 50
`define ALITM_MC_NS 600
// Least time, so round up to whole clocks
`define ALITM_MC_CLKS ((`ALITM_MC_NS + `ALITM_CLK_NS - 1) / `ALITM_CLK_NS)

`define ALITM_LEN_1 2'h1
`define ALITM_LEN_2 2'h2
`define ALITM_LEN_3 2'h3
`define ALITM_MC_1 3'h1
`define ALITM_MC_2 3'h2
`define ALITM_MC_4 3'h4

`define ALITM_LO_NIB 3:0
`define ALITM_HI_NIB 7:4
`define ALITM_LO7 6:0
`define ALITM_MSB 7
`define ALITM_BCD_MAX 4'h9
`define ALITM_ADJ_LO 8'h06
`define ALITM_ADJ_HI 8'h60
`define ALITM_RST_BYTE 8'h00
`define ALITM_RST_PTR 16'h0000
`endif

/* core/alitm_pkg.sv */
`default_nettype none
package alitm_pkg;
    typedef enum logic [4:0] {
        OP_SUM, OP_SUM_CARRY, OP_MINUS_BORROW, OP_BUMP_UP, OP_BUMP_DOWN, OP_PTR_UP,
        OP_PRODUCT, OP_QUOTIENT, OP_DECIMAL_ADJUST, OP_AND, OP_OR, OP_XOR,
        OP_ZERO_ACC, OP_INVERT_ACC, OP_ROT_L, OP_ROT_L_CARRY, OP_ROT_R, OP_ROT_R_CARRY,
        OP_NIBBLE_SWAP
    } alitm_op_e;
    typedef enum logic [2:0] {
        SRC_BANK, SRC_DIRECT, SRC_INDIRECT, SRC_IMMEDIATE, SRC_ACC
    } alitm_src_e;
    typedef enum logic [1:0] {
        TGT_ACC, TGT_BANK, TGT_INDIRECT, TGT_DIRECT
    } alitm_tgt_e;
endpackage : alitm_pkg
`default_nettype wire

/* core/alitm_muldiv.sv */
`timescale 1ns/1ps
`default_nettype none
module alitm_muldiv #(
    parameter int W = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_a,
    input wire logic [W-1:0] i_b,
    output logic [W-1:0] o_prod_lo,
    output logic [W-1:0] o_prod_hi,
    output logic [W-1:0] o_quot,
    output logic [W-1:0] o_rem
);
    logic [2*W-1:0] prod_next;
    logic [W-1:0] quot_next;
    logic [W-1:0] rem_next;

    // Operands stay still for the whole multi-cycle op, so one register stage is enough
    always_comb begin
        prod_next = (2*W)'(i_a) * (2*W)'(i_b);
        if (i_b == '0) begin
            quot_next = '0;
            rem_next = '0;
        end else begin
            quot_next = i_a / i_b;
            rem_next = i_a % i_b;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prod_lo <= '0;
            o_prod_hi <= '0;
            o_quot <= '0;
            o_rem <= '0;
        end else begin
            o_prod_lo <= prod_next[W-1:0];
            o_prod_hi <= prod_next[2*W-1:W];
            o_quot <= quot_next;
            o_rem <= rem_next;
        end
    end
endmodule : alitm_muldiv
`default_nettype wire

/* core/alitm_exec.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alitm_cfg.svh"
module alitm_exec #(
    parameter int CLK_PER_MC = `ALITM_MC_CLKS
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire alitm_pkg::alitm_op_e i_op,
    input wire alitm_pkg::alitm_src_e i_src,
    input wire logic i_dst_direct,
    input wire logic [7:0] i_bank_data,
    input wire logic [7:0] i_ind_data,
    input wire logic [7:0] i_dir_data,
    input wire logic i_dir_is_port,
    input wire logic [7:0] i_port_latch,
    input wire logic [7:0] i_imm_data,
    input wire logic i_acc_wr,
    input wire logic [7:0] i_acc_wdata,
    input wire logic i_b_wr,
    input wire logic [7:0] i_b_wdata,
    input wire logic i_cy_wr,
    input wire logic i_cy_wdata,
    output logic o_busy,
    output logic o_done,
    output logic [1:0] o_len,
    output logic [2:0] o_mcycles,
    output logic [7:0] o_acc,
    output logic [7:0] o_b,
    output logic [15:0] o_data_pointer_pair,
    output logic o_cy,
    output logic o_half_borrow_flag,
    output logic o_signed_excess_flag,
    output logic o_wr_en,
    output alitm_pkg::alitm_tgt_e o_wr_tgt,
    output logic [7:0] o_wr_data
);
    typedef enum logic {ST_IDLE, ST_RUN} alitm_state_e;

    alitm_state_e state_reg, state_next;
    alitm_pkg::alitm_op_e op_reg, op_next;
    alitm_pkg::alitm_tgt_e tgt_reg, tgt_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [7:0] x_reg, x_next;
    logic [7:0] opnd_reg, opnd_next;
    logic [7:0] acc_reg, acc_next;
    logic [7:0] b_reg, b_next;
    logic [15:0] dp_reg, dp_next;
    logic cy_reg, cy_next, hb_reg, hb_next, sx_reg, sx_next;
    logic [1:0] len_reg, len_next;
    logic [2:0] mc_reg, mc_next;
    logic done_reg, done_next, wr_en_reg, wr_en_next;
    logic [7:0] wr_data_reg, wr_data_next;
    logic [7:0] prod_lo, prod_hi, quot, rem;

    logic is_logic, rmw, commit;
    logic [7:0] dir_val, src_val, res;
    logic [8:0] s9, d9, t9;
    logic [4:0] h5;
    logic [7:0] l8;

    alitm_muldiv #(.W(8)) u_muldiv (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_a(acc_reg),
        .i_b(b_reg),
        .o_prod_lo(prod_lo),
        .o_prod_hi(prod_hi),
        .o_quot(quot),
        .o_rem(rem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        tgt_next = tgt_reg;
        cnt_next = cnt_reg;
        x_next = x_reg;
        opnd_next = opnd_reg;
        acc_next = acc_reg;
        b_next = b_reg;
        dp_next = dp_reg;
        cy_next = cy_reg;
        hb_next = hb_reg;
        sx_next = sx_reg;
        len_next = len_reg;
        mc_next = mc_reg;
        done_next = 1'b0;
        wr_en_next = 1'b0;
        wr_data_next = wr_data_reg;
        res = x_reg;
        s9 = '0;
        d9 = '0;
        t9 = '0;
        h5 = '0;
        l8 = '0;
        is_logic = (i_op == alitm_pkg::OP_AND) || (i_op == alitm_pkg::OP_OR) ||
                   (i_op == alitm_pkg::OP_XOR);
        rmw = i_dst_direct || (i_src == alitm_pkg::SRC_DIRECT &&
              (i_op == alitm_pkg::OP_BUMP_UP || i_op == alitm_pkg::OP_BUMP_DOWN));
        // Read-modify-write of a port takes the latch so pin loading cannot corrupt bits
        dir_val = (rmw && i_dir_is_port) ? i_port_latch : i_dir_data;
        case (i_src)
            alitm_pkg::SRC_BANK: src_val = i_bank_data;
            alitm_pkg::SRC_DIRECT: src_val = dir_val;
            alitm_pkg::SRC_INDIRECT: src_val = i_ind_data;
            alitm_pkg::SRC_IMMEDIATE: src_val = i_imm_data;
            default: src_val = acc_reg;
        endcase
        commit = (state_reg == ST_RUN) && (cnt_reg == 8'h01);

        case (state_reg)
            ST_IDLE: begin
                if (i_acc_wr) begin
                    acc_next = i_acc_wdata;
                end
                if (i_b_wr) begin
                    b_next = i_b_wdata;
                end
                if (i_cy_wr) begin
                    cy_next = i_cy_wdata;
                end
                if (i_start) begin
                    state_next = ST_RUN;
                    op_next = i_op;
                    tgt_next = alitm_pkg::TGT_ACC;
                    x_next = acc_reg;
                    opnd_next = src_val;
                    len_next = (i_src == alitm_pkg::SRC_DIRECT ||
                                i_src == alitm_pkg::SRC_IMMEDIATE) ?
                               `ALITM_LEN_2 : `ALITM_LEN_1;
                    mc_next = `ALITM_MC_1;
                    if (is_logic && i_dst_direct) begin
                        tgt_next = alitm_pkg::TGT_DIRECT;
                        x_next = dir_val;
                        if (i_src == alitm_pkg::SRC_IMMEDIATE) begin
                            len_next = `ALITM_LEN_3;
                            mc_next = `ALITM_MC_2;
                        end else begin
                            opnd_next = acc_reg;
                            len_next = `ALITM_LEN_2;
                        end
                    end else if (i_op == alitm_pkg::OP_BUMP_UP ||
                                 i_op == alitm_pkg::OP_BUMP_DOWN) begin
                        x_next = src_val;
                        case (i_src)
                            alitm_pkg::SRC_BANK: tgt_next = alitm_pkg::TGT_BANK;
                            alitm_pkg::SRC_DIRECT: tgt_next = alitm_pkg::TGT_DIRECT;
                            alitm_pkg::SRC_INDIRECT: tgt_next = alitm_pkg::TGT_INDIRECT;
                            default: tgt_next = alitm_pkg::TGT_ACC;
                        endcase
                    end else if (i_op == alitm_pkg::OP_PTR_UP) begin
                        len_next = `ALITM_LEN_1;
                        mc_next = `ALITM_MC_2;
                    end else if (i_op == alitm_pkg::OP_PRODUCT ||
                                 i_op == alitm_pkg::OP_QUOTIENT) begin
                        len_next = `ALITM_LEN_1;
                        mc_next = `ALITM_MC_4;
                    end else if (!(i_op == alitm_pkg::OP_SUM ||
                                   i_op == alitm_pkg::OP_SUM_CARRY ||
                                   i_op == alitm_pkg::OP_MINUS_BORROW || is_logic)) begin
                        len_next = `ALITM_LEN_1;
                    end
                    cnt_next = 8'(mc_next * CLK_PER_MC);
                end
            end
            ST_RUN: begin
                cnt_next = cnt_reg - 8'h01;
                if (commit) begin
                    state_next = ST_IDLE;
                    done_next = 1'b1;
                    case (op_reg)
                        alitm_pkg::OP_SUM, alitm_pkg::OP_SUM_CARRY: begin
                            l8 = {7'h00, (op_reg == alitm_pkg::OP_SUM_CARRY) & cy_reg};
                            s9 = 9'(x_reg) + 9'(opnd_reg) + 9'(l8);
                            h5 = 5'(x_reg[`ALITM_LO_NIB]) + 5'(opnd_reg[`ALITM_LO_NIB]) + 5'(l8);
                            t9 = 9'(x_reg[`ALITM_LO7]) + 9'(opnd_reg[`ALITM_LO7]) + 9'(l8);
                            res = s9[7:0];
                            cy_next = s9[8];
                            hb_next = h5[4];
                            sx_next = t9[`ALITM_MSB] ^ s9[8];
                        end
                        alitm_pkg::OP_MINUS_BORROW: begin
                            d9 = 9'(x_reg) - 9'(opnd_reg) - 9'(cy_reg);
                            h5 = 5'(x_reg[`ALITM_LO_NIB]) - 5'(opnd_reg[`ALITM_LO_NIB]) -
                                 5'(cy_reg);
                            t9 = 9'(x_reg[`ALITM_LO7]) - 9'(opnd_reg[`ALITM_LO7]) - 9'(cy_reg);
                            res = d9[7:0];
                            cy_next = d9[8];
                            hb_next = h5[4];
                            sx_next = t9[`ALITM_MSB] ^ d9[8];
                        end
                        alitm_pkg::OP_BUMP_UP: res = x_reg + 8'h01;
                        alitm_pkg::OP_BUMP_DOWN: res = x_reg - 8'h01;
                        alitm_pkg::OP_PTR_UP: dp_next = dp_reg + 16'h0001;
                        alitm_pkg::OP_PRODUCT: begin
                            res = prod_lo;
                            b_next = prod_hi;
                            cy_next = 1'b0;
                            sx_next = (prod_hi != 8'h00);
                        end
                        alitm_pkg::OP_QUOTIENT: begin
                            // Divide by zero leaves A and B as they were and flags overflow
                            res = (b_reg == 8'h00) ? x_reg : quot;
                            b_next = (b_reg == 8'h00) ? b_reg : rem;
                            cy_next = 1'b0;
                            sx_next = (b_reg == 8'h00);
                        end
                        alitm_pkg::OP_DECIMAL_ADJUST: begin
                            s9 = {cy_reg, x_reg};
                            if (x_reg[`ALITM_LO_NIB] > `ALITM_BCD_MAX || hb_reg) begin
                                s9 = s9 + 9'(`ALITM_ADJ_LO);
                            end
                            if (s9[`ALITM_HI_NIB] > `ALITM_BCD_MAX || s9[8]) begin
                                s9 = s9 + 9'(`ALITM_ADJ_HI);
                                s9[8] = 1'b1;
                            end
                            res = s9[7:0];
                            cy_next = s9[8] | cy_reg;
                        end
                        alitm_pkg::OP_AND: res = x_reg & opnd_reg;
                        alitm_pkg::OP_OR: res = x_reg | opnd_reg;
                        alitm_pkg::OP_XOR: res = x_reg ^ opnd_reg;
                        alitm_pkg::OP_ZERO_ACC: res = `ALITM_RST_BYTE;
                        alitm_pkg::OP_INVERT_ACC: res = ~x_reg;
                        alitm_pkg::OP_ROT_L: res = {x_reg[6:0], x_reg[`ALITM_MSB]};
                        alitm_pkg::OP_ROT_L_CARRY: begin
                            res = {x_reg[6:0], cy_reg};
                            cy_next = x_reg[`ALITM_MSB];
                        end
                        alitm_pkg::OP_ROT_R: res = {x_reg[0], x_reg[7:1]};
                        alitm_pkg::OP_ROT_R_CARRY: begin
                            res = {cy_reg, x_reg[7:1]};
                            cy_next = x_reg[0];
                        end
                        alitm_pkg::OP_NIBBLE_SWAP:
                            res = {x_reg[`ALITM_LO_NIB], x_reg[`ALITM_HI_NIB]};
                        default: res = x_reg;
                    endcase
                    if (op_reg != alitm_pkg::OP_PTR_UP) begin
                        if (tgt_reg == alitm_pkg::TGT_ACC) begin
                            acc_next = res;
                        end else begin
                            wr_en_next = 1'b1;
                            wr_data_next = res;
                        end
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= ST_IDLE;
            op_reg <= alitm_pkg::OP_SUM;
            tgt_reg <= alitm_pkg::TGT_ACC;
            cnt_reg <= '0;
            x_reg <= `ALITM_RST_BYTE;
            opnd_reg <= `ALITM_RST_BYTE;
            acc_reg <= `ALITM_RST_BYTE;
            b_reg <= `ALITM_RST_BYTE;
            dp_reg <= `ALITM_RST_PTR;
            cy_reg <= 1'b0;
            hb_reg <= 1'b0;
            sx_reg <= 1'b0;
            len_reg <= `ALITM_LEN_1;
            mc_reg <= `ALITM_MC_1;
            done_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_data_reg <= `ALITM_RST_BYTE;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            tgt_reg <= tgt_next;
            cnt_reg <= cnt_next;
            x_reg <= x_next;
            opnd_reg <= opnd_next;
            acc_reg <= acc_next;
            b_reg <= b_next;
            dp_reg <= dp_next;
            cy_reg <= cy_next;
            hb_reg <= hb_next;
            sx_reg <= sx_next;
            len_reg <= len_next;
            mc_reg <= mc_next;
            done_reg <= done_next;
            wr_en_reg <= wr_en_next;
            wr_data_reg <= wr_data_next;
        end
    end

    assign o_busy = (state_reg == ST_RUN);
    assign o_done = done_reg;
    assign o_len = len_reg;
    assign o_mcycles = mc_reg;
    assign o_acc = acc_reg;
    assign o_b = b_reg;
    assign o_data_pointer_pair = dp_reg;
    assign o_cy = cy_reg;
    assign o_half_borrow_flag = hb_reg;
    assign o_signed_excess_flag = sx_reg;
    assign o_wr_en = wr_en_reg;
    assign o_wr_tgt = tgt_reg;
    assign o_wr_data = wr_data_reg;

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] run_clks_reg;
    localparam int RMW_WAIT = int'(`ALITM_MC_2) * CLK_PER_MC;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_clks_reg <= '0;
        end else if (state_reg == ST_IDLE) begin
            run_clks_reg <= '0;
        end else begin
            run_clks_reg <= run_clks_reg + 8'h01;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    sum_one_cycle_a: assert property (
        o_done && op_reg == alitm_pkg::OP_SUM |-> run_clks_reg == 8'(CLK_PER_MC))
        else $error("sum did not take one machine cycle");
    sum_carry_a: assert property (
        o_done && op_reg == alitm_pkg::OP_SUM_CARRY && tgt_reg == alitm_pkg::TGT_ACC |->
        {o_cy, o_acc} == 9'(x_reg) + 9'(opnd_reg) + 9'($past(o_cy)))
        else $error("sum with carry result wrong");
    borrow_carry_a: assert property (
        o_done && op_reg == alitm_pkg::OP_MINUS_BORROW |->
        o_cy == (9'(x_reg) < 9'(opnd_reg) + 9'($past(o_cy))))
        else $error("borrow flag wrong");
    rmw_three_byte_a: assert property (
        $rose(o_busy) && tgt_reg == alitm_pkg::TGT_DIRECT && op_reg != alitm_pkg::OP_BUMP_UP &&
        op_reg != alitm_pkg::OP_BUMP_DOWN && o_len == `ALITM_LEN_3 |->
        o_mcycles == `ALITM_MC_2 ##RMW_WAIT o_done && o_wr_en)
        else $error("direct immediate logic op timing wrong");
    muldiv_four_a: assert property (
        o_done && (op_reg == alitm_pkg::OP_PRODUCT || op_reg == alitm_pkg::OP_QUOTIENT) |->
        run_clks_reg == 8'(`ALITM_MC_4 * CLK_PER_MC) && o_len == `ALITM_LEN_1)
        else $error("multiply or divide length wrong");
    swap_flags_a: assert property (
        o_done && op_reg == alitm_pkg::OP_NIBBLE_SWAP |->
        o_acc == {x_reg[`ALITM_LO_NIB], x_reg[`ALITM_HI_NIB]} && $stable(o_cy) &&
        $stable(o_half_borrow_flag) && $stable(o_signed_excess_flag))
        else $error("nibble exchange wrong");
    rot_left_carry_a: assert property (
        o_done && op_reg == alitm_pkg::OP_ROT_L_CARRY |-> {o_cy, o_acc} == {x_reg, $past(o_cy)})
        else $error("left rotate through carry wrong");
    rot_right_carry_a: assert property (
        o_done && op_reg == alitm_pkg::OP_ROT_R_CARRY |-> {o_acc, o_cy} == {$past(o_cy), x_reg})
        else $error("right rotate through carry wrong");
    xor_direct_a: assert property (
        o_done && op_reg == alitm_pkg::OP_XOR && tgt_reg == alitm_pkg::TGT_DIRECT |->
        o_wr_en && o_wr_data == (x_reg ^ opnd_reg) && $stable(o_acc))
        else $error("xor into direct byte wrong");
    port_latch_a: assert property (
        !o_busy && i_start && i_dst_direct && i_dir_is_port && (i_op == alitm_pkg::OP_AND ||
        i_op == alitm_pkg::OP_OR || i_op == alitm_pkg::OP_XOR) |=> x_reg == $past(i_port_latch))
        else $error("port read-modify-write did not use latch");

    product_seen_c: cover property (o_done && op_reg == alitm_pkg::OP_PRODUCT);
    borrow_seen_c: cover property (o_done && op_reg == alitm_pkg::OP_MINUS_BORROW &&
        o_signed_excess_flag);
    and_direct_c: cover property (o_done && op_reg == alitm_pkg::OP_AND && o_wr_en);
    back_to_back_c: cover property (o_done && i_start);
endmodule : alitm_exec
`default_nettype wire

/* verif/arith_logic_instr_timing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module arith_logic_instr_timing_tb;
    // One clock per machine cycle keeps every walk short
    localparam int MC = 1;
    localparam alitm_pkg::alitm_src_e SB = alitm_pkg::SRC_BANK;
    localparam alitm_pkg::alitm_src_e SD = alitm_pkg::SRC_DIRECT;
    localparam alitm_pkg::alitm_src_e SI = alitm_pkg::SRC_INDIRECT;
    localparam alitm_pkg::alitm_src_e SM = alitm_pkg::SRC_IMMEDIATE;
    localparam alitm_pkg::alitm_src_e SA = alitm_pkg::SRC_ACC;
    logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_start = 1'b0, i_dst_direct = 1'b0;
    logic i_dir_is_port = 1'b0, i_acc_wr = 1'b0, i_b_wr = 1'b0, i_cy_wr = 1'b0, i_cy_wdata = 1'b0;
    logic [7:0] i_bank_data = 8'h00, i_ind_data = 8'h00, i_dir_data = 8'h00, i_imm_data = 8'h00;
    logic [7:0] i_port_latch = 8'h00, i_acc_wdata = 8'h00, i_b_wdata = 8'h00;
    alitm_pkg::alitm_op_e i_op = alitm_pkg::OP_SUM;
    alitm_pkg::alitm_src_e i_src = alitm_pkg::SRC_ACC;
    logic o_busy, o_done, o_cy, hb, sx, o_wr_en;
    logic [1:0] o_len;
    logic [2:0] o_mcycles;
    logic [7:0] o_acc, o_b, o_wr_data;
    logic [15:0] dp;
    alitm_pkg::alitm_tgt_e o_wr_tgt;
    int n_mismatch = 0, checks = 0, cycles = 0;
    alitm_exec #(.CLK_PER_MC(MC)) DUT (.i_core_clk, .i_rst_b, .i_start, .i_op, .i_src,
        .i_dst_direct, .i_bank_data, .i_ind_data, .i_dir_data, .i_dir_is_port, .i_port_latch,
        .i_imm_data, .i_acc_wr, .i_acc_wdata, .i_b_wr, .i_b_wdata, .i_cy_wr, .i_cy_wdata,
        .o_busy, .o_done, .o_len, .o_mcycles, .o_acc, .o_b, .o_data_pointer_pair(dp), .o_cy,
        .o_half_borrow_flag(hb), .o_signed_excess_flag(sx), .o_wr_en, .o_wr_tgt, .o_wr_data);
    always #25 i_core_clk = ~i_core_clk;
    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task load(input logic [7:0] a, input logic [7:0] b, input logic c);
        @(negedge i_core_clk);
        {i_acc_wr, i_b_wr, i_cy_wr, i_acc_wdata, i_b_wdata, i_cy_wdata} = {3'h7, a, b, c};
        @(negedge i_core_clk);
        {i_acc_wr, i_b_wr, i_cy_wr} = 3'h0;
    endtask : load
    // Unselected bank, indirect and immediate sources carry the inverse so a wrong pick shows up in the result
    task run(input alitm_pkg::alitm_op_e op, input alitm_pkg::alitm_src_e src, input logic dd,
             input logic [7:0] v, input logic [7:0] d, input logic [1:0] len, input logic [2:0] mc);
        int n;
        n = 0;
        @(negedge i_core_clk);
        {i_start, i_op, i_src, i_dst_direct} = {1'b1, op, src, dd};
        i_bank_data = (src == SB) ? v : ~v;
        i_ind_data = (src == SI) ? v : ~v;
        i_imm_data = (src == SM) ? v : ~v;
        i_dir_data = (src == SD) ? v : d;
        // Start is taken at the edge before this one; count edges from there to done
        @(negedge i_core_clk);
        i_start = 1'b0;
        check(o_busy, 1'b1);
        while (n < 20 && o_done !== 1'b1) begin
            @(negedge i_core_clk);
            n++;
        end
        check(o_busy, 1'b0);
        check(16'(o_len), 16'(len));
        check(16'(o_mcycles), 16'(mc));
        check(16'(n), 16'(mc * MC));
    endtask : run
    ////////////////////////////////////////////////////////////////
    task t_arith;
        load(8'h03, 8'h00, 1'b0);
        run(alitm_pkg::OP_SUM, SM, 1'b0, 8'h05, 8'h00, 2'h2, 3'h1);
        check(o_acc, 8'h08);
        load(8'h80, 8'h00, 1'b1);
        run(alitm_pkg::OP_SUM_CARRY, SB, 1'b0, 8'h7f, 8'h00, 2'h1, 3'h1);
        check({o_cy, o_acc}, 9'h100);
        run(alitm_pkg::OP_SUM_CARRY, SD, 1'b0, 8'h01, 8'h00, 2'h2, 3'h1);
        check({o_cy, o_acc}, 9'h002);
        load(8'hc9, 8'h00, 1'b1);
        run(alitm_pkg::OP_MINUS_BORROW, SB, 1'b0, 8'h54, 8'h00, 2'h1, 3'h1);
        check({o_cy, hb, sx, o_acc}, 11'h174);
        load(8'h10, 8'h00, 1'b0);
        run(alitm_pkg::OP_MINUS_BORROW, SD, 1'b0, 8'h01, 8'h00, 2'h2, 3'h1);
        check({o_cy, hb, sx, o_acc}, 11'h20f);
        run(alitm_pkg::OP_MINUS_BORROW, SI, 1'b0, 8'h10, 8'h00, 2'h1, 3'h1);
        check({o_cy, hb, sx, o_acc}, 11'h4ff);
        run(alitm_pkg::OP_MINUS_BORROW, SM, 1'b0, 8'h7f, 8'h00, 2'h2, 3'h1);
        check({o_cy, hb, sx, o_acc}, 11'h37f);
    endtask : t_arith
    task t_logic;
        load(8'h0f, 8'h00, 1'b0);
        {i_dir_is_port, i_port_latch} = {1'b1, 8'haa};
        run(alitm_pkg::OP_AND, SM, 1'b1, 8'h3c, 8'hf0, 2'h3, 3'h2);
        check({o_wr_en, o_wr_tgt, o_wr_data, o_acc}, 19'h7_28_0f);
        run(alitm_pkg::OP_AND, SA, 1'b1, 8'h00, 8'hf0, 2'h2, 3'h1);
        check(o_wr_data, 8'h0a);
        i_dir_is_port = 1'b0;
        run(alitm_pkg::OP_OR, SM, 1'b1, 8'h0c, 8'h30, 2'h3, 3'h2);
        check(o_wr_data, 8'h3c);
        run(alitm_pkg::OP_XOR, SM, 1'b1, 8'hff, 8'h5a, 2'h3, 3'h2);
        check(o_wr_data, 8'ha5);
        run(alitm_pkg::OP_XOR, SA, 1'b1, 8'h00, 8'hf0, 2'h2, 3'h1);
        check(o_wr_data, 8'hff);
        run(alitm_pkg::OP_OR, SB, 1'b0, 8'h30, 8'h00, 2'h1, 3'h1);
        check({o_wr_en, o_acc}, 9'h03f);
        run(alitm_pkg::OP_AND, SI, 1'b0, 8'h3c, 8'h00, 2'h1, 3'h1);
        check(o_acc, 8'h3c);
        run(alitm_pkg::OP_XOR, SD, 1'b0, 8'h0f, 8'h00, 2'h2, 3'h1);
        check(o_acc, 8'h33);
    endtask : t_logic
    task t_rotate;
        load(8'h81, 8'h00, 1'b0);
        run(alitm_pkg::OP_ROT_L_CARRY, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h1);
        check({o_cy, o_acc}, 9'h102);
        run(alitm_pkg::OP_ROT_R_CARRY, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h1);
        check({o_cy, o_acc}, 9'h081);
        run(alitm_pkg::OP_ROT_L, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h1);
        check({o_cy, o_acc}, 9'h003);
        run(alitm_pkg::OP_ROT_R, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h1);
        check({o_cy, o_acc}, 9'h081);
        load(8'hc5, 8'h00, 1'b1);
        run(alitm_pkg::OP_NIBBLE_SWAP, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h1);
        check({o_cy, o_acc}, 9'h15c);
    endtask : t_rotate
    task t_misc;
        load(8'h10, 8'h20, 1'b1);
        run(alitm_pkg::OP_PRODUCT, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h4);
        check({o_cy, sx, o_b, o_acc}, 18'h10200);
        load(8'h25, 8'h07, 1'b0);
        run(alitm_pkg::OP_QUOTIENT, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h4);
        check({o_b, o_acc}, 16'h0205);
        load(8'h0b, 8'h00, 1'b0);
        run(alitm_pkg::OP_DECIMAL_ADJUST, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h1);
        check(o_acc, 8'h11);
        run(alitm_pkg::OP_INVERT_ACC, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h1);
        check(o_acc, 8'hee);
        run(alitm_pkg::OP_ZERO_ACC, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h1);
        check(o_acc, 8'h00);
        run(alitm_pkg::OP_BUMP_DOWN, SB, 1'b0, 8'h00, 8'h00, 2'h1, 3'h1);
        check({o_wr_en, o_wr_tgt, o_wr_data}, 11'h5ff);
        run(alitm_pkg::OP_BUMP_UP, SD, 1'b0, 8'h41, 8'h00, 2'h2, 3'h1);
        check({o_wr_en, o_wr_tgt, o_wr_data}, 11'h742);
        run(alitm_pkg::OP_PTR_UP, SA, 1'b0, 8'h00, 8'h00, 2'h1, 3'h2);
        check(dp, 16'h0001);
    endtask : t_misc
    ////////////////////////////////////////////////////////////////
    // Ceiling is over twenty times the cycles the scenarios need
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (20) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        check({o_len, o_mcycles, o_acc, o_wr_tgt}, 15'h2400);
        t_arith();
        t_logic();
        t_rotate();
        t_misc();
        tally_and_finish();
    end
endmodule : arith_logic_instr_timing_tb
`default_nettype wire
